// file: pbm_pkg.sv
/*
  Shared constants and types for the port-B bus-matching and byte-swap block.
  Assumes a single 50 MHz clock domain and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package pbm_pkg;
  localparam int DATA_W  = 36;
  localparam int HALF_W  = 18;
  localparam int BYTE_W  = 9;
  localparam int ADDR_W  = 8;
  localparam int EVT_W   = 4;

  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MASK    = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATE   = 8'h0c;

  localparam logic [3:0] MASK_RESET  = 4'h0;
  localparam int CTL_PAR_EN  = 0;
  localparam int CTL_PAR_ODD = 1;
  localparam logic [1:0] CTL_RESET   = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] LAST_WORD   = 2'h1;
  localparam logic [1:0] LAST_BYTE   = 2'h3;

  // Order follows the code on the two size-select pins.
  typedef enum logic [1:0] {SZ_LONG, SZ_WORD, SZ_BYTE, SZ_MAIL} pbm_size_t;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic mailIn;
    logic parity;
  } pbm_evt_t;

  typedef struct packed {
    pbm_size_t  size;
    logic [1:0] swap;
    logic       big;
  } pbm_sel_t;
endpackage
`default_nettype wire

// file: pbm_port_b.sv
/*
  Port-B bus matching, byte swapping, mailbox access and parity check.
  Assumes queues with valid/ready handshakes outside, a host on port B
  synchronous to clock, and software on AXI4-Lite.
*/
`timescale 1ns/100ps
`default_nettype none
module pbm_port_b
  import pbm_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq,
  input  wire logic              portBEnable,
  input  wire logic              portBDirRead,
  input  wire logic [DATA_W-1:0] portBDataIn,
  output logic [DATA_W-1:0]      portBDataOut,
  output logic                   portBDataOe,
  input  wire logic              portBSizeSelLo,
  input  wire logic              portBSizeSelHi,
  input  wire logic              swapSelLo,
  input  wire logic              swapSelHi,
  input  wire logic              endianSelect,
  output logic                   portBParityErrorFlagN,
  input  wire logic [DATA_W-1:0] aToBQueueData,
  input  wire logic              aToBQueueValid,
  output logic                   aToBQueueReady,
  output logic [DATA_W-1:0]      bToAQueueData,
  output logic                   bToAQueueValid,
  input  wire logic              bToAQueueReady,
  input  wire logic [DATA_W-1:0] outboundMailbox,
  output logic [DATA_W-1:0]      inboundMailbox
);

  function automatic logic [DATA_W-1:0] swapFn(input logic [DATA_W-1:0] w, input logic [1:0] c);
    case (c)
      2'h1:    swapFn = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2:    swapFn = {w[17:0], w[35:18]};
      2'h3:    swapFn = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: swapFn = w;
    endcase
  endfunction

  // Lowest bit of the byte lane of the long word that a given piece occupies.
  function automatic logic [5:0] laneBase(input logic [1:0] ph, input logic big);
    logic [1:0] idx;
    idx = big ? 2'(2'h3 - ph) : ph;
    laneBase = 6'(idx) * 6'd9;
  endfunction

  pbm_sel_t        sel;
  logic            wrReq;
  logic            rdReq;
  logic            fifoWr;
  logic            fifoRd;
  logic            mailWr;
  logic            mailRd;
  logic [1:0]      wrPhase;
  logic [1:0]      rdPhase;
  logic [1:0]      wrSwapUse;
  logic            wrLast;
  logic            pushFree;
  logic            wrTake;
  logic            wrRefuse;
  logic            rdTake;
  logic            rdRefuse;
  logic [DATA_W-1:0] asm;
  logic [DATA_W-1:0] rdSrc;
  logic [DATA_W-1:0] dout_nxt;
  logic [3:0]      laneBad;
  logic [3:0]      laneMask;
  logic            parErr;
  pbm_evt_t        evt;

  logic [1:0]      wrPh_r;
  pbm_size_t       wrSize_r;
  logic [1:0]      wrSwap_r;
  logic [DATA_W-1:0] wrAux_r;
  logic [1:0]      rdPh_r;
  pbm_size_t       rdSize_r;
  logic [DATA_W-1:0] rdWord_r;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] push_r;
  logic            pushValid_r;
  logic [DATA_W-1:0] mailIn_r;
  logic            parN_r;
  logic [EVT_W-1:0] status_r;
  logic [EVT_W-1:0] mask_r;
  logic [1:0]      ctl_r;

  assign sel.size = pbm_size_t'({portBSizeSelHi, portBSizeSelLo});
  assign sel.swap = {swapSelHi, swapSelLo};
  assign sel.big  = endianSelect;

  assign wrReq  = portBEnable && !portBDirRead;
  assign rdReq  = portBEnable && portBDirRead;
  assign mailWr = wrReq && (sel.size == SZ_MAIL);
  assign mailRd = rdReq && (sel.size == SZ_MAIL);
  assign fifoWr = wrReq && (sel.size != SZ_MAIL);
  assign fifoRd = rdReq && (sel.size != SZ_MAIL);

  // A new bus size restarts assembly; held pieces are lost if the host
  // changes size mid-word, so it must not.
  assign wrPhase = (sel.size != wrSize_r) ? 2'h0 : wrPh_r;
  assign rdPhase = (sel.size != rdSize_r) ? 2'h0 : rdPh_r;

  assign wrSwapUse = (wrPhase == 2'h0) ? sel.swap : wrSwap_r;
  assign wrLast = (sel.size == SZ_LONG)
                || (sel.size == SZ_WORD && wrPhase == LAST_WORD)
                || (sel.size == SZ_BYTE && wrPhase == LAST_BYTE);
  assign pushFree = !pushValid_r || bToAQueueReady;
  assign wrTake   = fifoWr && pushFree;
  assign wrRefuse = fifoWr && !pushFree;

  assign rdTake   = fifoRd && (rdPhase != 2'h0 || aToBQueueValid);
  assign rdRefuse = fifoRd && !rdTake;
  assign aToBQueueReady = fifoRd && rdPhase == 2'h0 && aToBQueueValid;

  always_comb begin
    asm = wrAux_r;
    case (sel.size)
      SZ_WORD: begin
        if (sel.big ^ wrPhase[0]) begin
          asm[35:18] = sel.big ? portBDataIn[35:18] : portBDataIn[17:0];
        end else begin
          asm[17:0] = sel.big ? portBDataIn[35:18] : portBDataIn[17:0];
        end
      end
      SZ_BYTE: begin
        asm[laneBase(wrPhase, sel.big) +: BYTE_W] =
          sel.big ? portBDataIn[35:27] : portBDataIn[8:0];
      end
      default: asm = portBDataIn;
    endcase
  end

  assign rdSrc = (rdPhase == 2'h0) ? swapFn(aToBQueueData, sel.swap) : rdWord_r;

  always_comb begin
    dout_nxt = dout_r;
    if (mailRd) begin
      dout_nxt = outboundMailbox;
    end else if (rdTake) begin
      case (sel.size)
        SZ_WORD: begin
          // Only one half moves; the other keeps its last value.
          if (sel.big) begin
            dout_nxt[35:18] = rdPhase[0] ? rdSrc[17:0] : rdSrc[35:18];
          end else begin
            dout_nxt[17:0] = rdPhase[0] ? rdSrc[35:18] : rdSrc[17:0];
          end
        end
        SZ_BYTE: begin
          if (sel.big) begin
            dout_nxt[35:27] = rdSrc[laneBase(rdPhase, 1'b1) +: BYTE_W];
          end else begin
            dout_nxt[8:0] = rdSrc[laneBase(rdPhase, 1'b0) +: BYTE_W];
          end
        end
        default: dout_nxt = rdSrc;
      endcase
    end
  end

  always_comb begin
    laneBad = '0;
    for (int i = 0; i < 4; i++) begin
      laneBad[i] = ~^portBDataIn[i*BYTE_W +: BYTE_W] ^ !ctl_r[CTL_PAR_ODD];
    end
    case (sel.size)
      SZ_WORD: laneMask = sel.big ? 4'hc : 4'h3;
      SZ_BYTE: laneMask = sel.big ? 4'h8 : 4'h2;
      default: laneMask = 4'hf;
    endcase
  end
  assign parErr = wrReq && ctl_r[CTL_PAR_EN] && |(laneBad & laneMask);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrPh_r   <= 2'h0;
      wrSize_r <= SZ_LONG;
      wrSwap_r <= 2'h0;
      wrAux_r  <= '0;
    end else if (wrTake) begin
      wrSize_r <= sel.size;
      wrSwap_r <= wrSwapUse;
      wrAux_r  <= asm;
      wrPh_r   <= wrLast ? 2'h0 : 2'(wrPhase + 2'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pushValid_r <= 1'b0;
      push_r      <= '0;
    end else if (wrTake && wrLast) begin
      pushValid_r <= 1'b1;
      push_r      <= swapFn(asm, wrSwapUse);
    end else if (bToAQueueReady) begin
      pushValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdPh_r   <= 2'h0;
      rdSize_r <= SZ_LONG;
      rdWord_r <= '0;
    end else if (rdTake) begin
      rdSize_r <= sel.size;
      if (rdPhase == 2'h0) begin
        rdWord_r <= rdSrc;
      end
      if (sel.size == SZ_LONG || (sel.size == SZ_WORD && rdPhase == LAST_WORD)) begin
        rdPh_r <= 2'h0;
      end else begin
        rdPh_r <= 2'(rdPhase + 2'h1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dout_r   <= '0;
      mailIn_r <= '0;
      parN_r   <= 1'b1;
    end else begin
      dout_r <= dout_nxt;
      parN_r <= !parErr;
      if (mailWr) begin
        mailIn_r <= portBDataIn;
      end
    end
  end

  assign portBDataOut          = dout_r;
  assign portBDataOe           = portBDirRead;
  assign portBParityErrorFlagN = parN_r;
  assign bToAQueueData         = push_r;
  assign bToAQueueValid        = pushValid_r;
  assign inboundMailbox        = mailIn_r;

  // Register bus: address and data are held separately, then applied together.
  logic              awHeld_r;
  logic              wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0]       wData_r;
  logic              wLane0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic              doWrite;
  logic              wrHit;
  logic              arHit;
  logic [31:0]       regRd;
  logic [EVT_W-1:0]  clrBits;

  assign evt.underflow = rdRefuse;
  assign evt.overflow  = wrRefuse;
  assign evt.mailIn    = mailWr;
  assign evt.parity    = parErr;

  assign awready = !awHeld_r && !bvalid_r;
  assign wready  = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign wrHit   = awAddr_r == OFS_STATUS || awAddr_r == OFS_MASK || awAddr_r == OFS_CONTROL
                || awAddr_r == OFS_STATE;
  assign arHit   = araddr == OFS_STATUS || araddr == OFS_MASK || araddr == OFS_CONTROL
                || araddr == OFS_STATE;
  assign clrBits = (doWrite && wLane0_r && awAddr_r == OFS_STATUS) ? wData_r[EVT_W-1:0] : '0;
  assign regRd   = (araddr == OFS_STATUS)  ? {28'h0, status_r} :
                   (araddr == OFS_MASK)    ? {28'h0, mask_r} :
                   (araddr == OFS_CONTROL) ? {30'h0, ctl_r} :
                   (araddr == OFS_STATE)   ? {23'h0, pushValid_r, rdSize_r, wrSize_r, rdPh_r, wrPh_r} :
                   32'h0;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= '0;
      wLane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r  <= 1'b1;
        wData_r  <= wdata;
        wLane0_r <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_r   <= MASK_RESET;
      ctl_r    <= CTL_RESET;
      status_r <= '0;
    end else begin
      // A new event in the clearing cycle survives the clear.
      status_r <= (status_r & ~clrBits) | evt;
      if (doWrite && wLane0_r && awAddr_r == OFS_MASK) begin
        mask_r <= wData_r[EVT_W-1:0];
      end
      if (doWrite && wLane0_r && awAddr_r == OFS_CONTROL) begin
        ctl_r <= wData_r[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= regRd;
      rresp_r  <= arHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;
  assign irq    = |(status_r & mask_r);

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  mail_store_a: assert property (mailWr |=> inboundMailbox == $past(portBDataIn))
    else $error("inbound mailbox not loaded");
  mail_read_a: assert property (mailRd |=> portBDataOut == $past(outboundMailbox))
    else $error("outbound mailbox not driven");
  long_read_a: assert property (fifoRd && sel.size == SZ_LONG && aToBQueueValid
    |=> portBDataOut == swapFn($past(aToBQueueData), $past(sel.swap)))
    else $error("long read swap wrong");
  long_write_a: assert property (wrTake && sel.size == SZ_LONG
    |=> bToAQueueValid && bToAQueueData == swapFn($past(portBDataIn), $past(sel.swap)))
    else $error("long write unswap wrong");
  word_hold_a: assert property (rdTake && sel.size == SZ_WORD && sel.big
    |=> portBDataOut[17:0] == $past(portBDataOut[17:0]))
    else $error("unused half changed");
  word_par_a: assert property (wrReq && sel.size == SZ_WORD && sel.big && laneBad[1:0] != 2'h0
    && laneBad[3:2] == 2'h0 |=> portBParityErrorFlagN)
    else $error("lower lanes checked in big word write");
  swap_hold_a: assert property (wrTake && wrPhase != 2'h0 |=> wrSwap_r == $past(wrSwap_r))
    else $error("swap changed mid word");
  byte_commit_a: assert property (wrTake && sel.size == SZ_BYTE && !wrLast && !pushValid_r
    |=> !bToAQueueValid)
    else $error("early commit on byte write");
  // The set must win over a clear written in the same cycle.
  status_set_a: assert property (evt != '0 |=> (status_r & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");

  byte_write_c: cover property (wrTake && sel.size == SZ_BYTE && wrLast);
  word_read_c: cover property (rdTake && sel.size == SZ_WORD && rdPhase == LAST_WORD);
  mail_write_c: cover property (mailWr ##1 wrTake);
  refuse_c: cover property (wrRefuse);
endmodule
`default_nettype wire

// file: pbm_far.sv
/*
  Far-side model of the two queues beside the port-B bus matcher.
  Assumes the bench preloads the inbound queue and opens or stalls the sink.
*/
`timescale 1ns/100ps
`default_nettype none
module pbm_far
  import pbm_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              sinkOpen,
  output logic [DATA_W-1:0]      aToBQueueData,
  output logic                   aToBQueueValid,
  input  wire logic              aToBQueueReady,
  input  wire logic [DATA_W-1:0] bToAQueueData,
  input  wire logic              bToAQueueValid,
  output logic                   bToAQueueReady
);
  logic [DATA_W-1:0] mem [8];
  logic [DATA_W-1:0] got [16];
  int                wp = 0;
  int                rp = 0;
  int                nGot = 0;
  assign aToBQueueValid = (wp != rp);
  // An empty queue shows inverted stale data, so a read of nothing cannot match by luck.
  assign aToBQueueData = aToBQueueValid ? mem[rp%8] : ~mem[(rp+7)%8];
  assign bToAQueueReady = sinkOpen;
  always @(posedge clock) begin
    if (aToBQueueValid && aToBQueueReady) begin
      rp <= rp + 1;
    end
    if (bToAQueueValid && bToAQueueReady) begin
      got[nGot%16] <= bToAQueueData;
      nGot <= nGot + 1;
    end
  end
  task push(input logic [DATA_W-1:0] w);
    mem[wp%8] = w;
    wp++;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench for the port-B bus matcher, with AXI4-Lite register tasks.
  Assumes pbm_far models both queues; the bench itself plays the port-B host.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pbm_pkg::*;
  localparam logic [35:0] W0  = {9'h003, 9'h005, 9'h006, 9'h009};
  localparam logic [8:0]  BAD = 9'h001;
  localparam logic [35:0] MO  = 36'h90a0b0c0d;
  logic              clock = 0, reset_n = 0, sinkOpen = 1;
  logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, irq, portBDataOe;
  logic [31:0]       wdata = 0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic [1:0]        bresp, rresp;
  logic              portBEnable = 0, portBDirRead = 0, endianSelect = 0;
  logic              portBSizeSelLo = 0, portBSizeSelHi = 0, swapSelLo = 0, swapSelHi = 0;
  logic [DATA_W-1:0] portBDataIn = 0, portBDataOut, aToBQueueData, bToAQueueData, inboundMailbox;
  logic [DATA_W-1:0] outboundMailbox = MO, expOut = 0, s;
  logic              portBParityErrorFlagN, aToBQueueValid, aToBQueueReady, bToAQueueValid, bToAQueueReady;
  int                miscompares = 0, nCompared = 0, nSeen = 0;

  pbm_port_b i_pbm_port_b (.*);
  pbm_far    i_pbm_far (.*);

  always #10 clock = ~clock;

  function automatic logic [35:0] sw(input logic [1:0] k, input logic [35:0] w);
    case (k)
      2'h0: sw = w;
      2'h1: sw = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: sw = {w[17:0], w[35:18]};
      default: sw = {w[26:18], w[35:27], w[8:0], w[17:9]};
    endcase
  endfunction

  task chk(input logic [35:0] seen, input logic [35:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("compares %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
    #1;
  endtask

  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
    #1;
  endtask

  // One port-B piece; it is taken at the edge that ends the next call.
  task pb(input logic rd, input logic [1:0] sz, input logic [1:0] k, input logic b, input logic [35:0] d);
    @(posedge clock);
    {portBEnable, portBDirRead, portBSizeSelHi, portBSizeSelLo} <= {1'b1, rd, sz};
    {swapSelHi, swapSelLo, endianSelect, portBDataIn} <= {k, b, d};
  endtask

  task idle;
    @(posedge clock);
    portBEnable <= 1'b0;
    #1;
  endtask

  task getq(input logic [35:0] e);
    while (i_pbm_far.nGot <= nSeen) @(posedge clock);
    chk(i_pbm_far.got[nSeen%16], e);
    nSeen++;
  endtask

  task t_regs;
    axr(OFS_CONTROL, {30'h0, CTL_RESET}, RESP_OKAY);
    axr(OFS_MASK, 32'h0, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'hf, RESP_SLVERR);
    pb(0, 2'h3, 2'h0, 1, W0);
    idle;
    chk(irq, 0);
    axw(OFS_MASK, 32'h2, RESP_OKAY);
    chk(irq, 1);
    axr(OFS_STATUS, 32'h2, RESP_OKAY);
    axw(OFS_STATUS, 32'h2, RESP_OKAY);
    chk(irq, 0);
    // Checking off: even a failing byte pattern leaves the flag high.
    axw(OFS_CONTROL, 32'h2, RESP_OKAY);
    pb(0, 2'h3, 2'h0, 1, W0);
    idle;
    chk(portBParityErrorFlagN, 1);
    // Odd parity: every byte of W0 has an even count of ones, so all fail.
    axw(OFS_CONTROL, 32'h3, RESP_OKAY);
    pb(0, 2'h3, 2'h0, 1, W0);
    idle;
    chk(portBParityErrorFlagN, 0);
    axw(OFS_CONTROL, {30'h0, CTL_RESET}, RESP_OKAY);
    axr(OFS_STATUS, 32'h3, RESP_OKAY);
    axw(OFS_STATUS, 32'hf, RESP_OKAY);
    $display("register test done");
  endtask

  task t_writes;
    for (int k = 0; k < 4; k++) pb(0, 2'h0, k[1:0], 1, sw(k[1:0], W0));
    idle;
    for (int k = 0; k < 4; k++) getq(W0);
    s = sw(2'h1, W0);
    pb(0, 2'h1, 2'h1, 1, {s[35:18], BAD, BAD});
    pb(0, 2'h3, 2'h0, 1, s);
    pb(0, 2'h1, 2'h2, 1, {s[17:0], BAD, BAD});
    idle;
    chk(portBParityErrorFlagN, 1);
    chk(inboundMailbox, s);
    chk(portBDataOe, 0);
    getq(W0);
    pb(0, 2'h1, 2'h0, 0, {BAD, BAD, W0[17:0]});
    pb(0, 2'h1, 2'h0, 0, {BAD, BAD, W0[35:18]});
    idle;
    getq(W0);
    s = sw(2'h3, W0);
    for (int i = 0; i < 4; i++) pb(0, 2'h2, 2'h3, 1, {s[35-9*i -: 9], BAD, BAD, BAD});
    idle;
    chk(portBParityErrorFlagN, 1);
    getq(W0);
    s = sw(2'h2, W0);
    for (int i = 0; i < 4; i++) pb(0, 2'h2, 2'h2, 0, {18'h0, BAD, s[9*i +: 9]});
    idle;
    chk(portBParityErrorFlagN, 0);
    getq(W0);
    sinkOpen <= 1'b0;
    pb(0, 2'h0, 2'h0, 1, W0);
    pb(0, 2'h0, 2'h0, 1, MO);
    idle;
    idle;
    chk(bToAQueueValid, 1);
    sinkOpen <= 1'b1;
    getq(W0);
    repeat (3) idle;
    chk(i_pbm_far.nGot, nSeen);
    $display("write test done");
  endtask

  task t_reads;
    for (int k = 0; k < 4; k++) begin
      i_pbm_far.push(W0);
      pb(1, 2'h0, k[1:0], 1, 0);
      idle;
      expOut = sw(k[1:0], W0);
      chk(portBDataOut, expOut);
    end
    i_pbm_far.push(W0);
    s = sw(2'h2, W0);
    for (int i = 0; i < 2; i++) begin
      pb(1, 2'h1, i ? 2'h0 : 2'h2, 1, 0);
      idle;
      expOut[35:18] = i ? s[17:0] : s[35:18];
      chk(portBDataOut, expOut);
    end
    i_pbm_far.push(W0);
    s = sw(2'h1, W0);
    for (int i = 0; i < 2; i++) begin
      pb(1, 2'h1, 2'h1, 0, 0);
      idle;
      expOut[17:0] = i ? s[35:18] : s[17:0];
      chk(portBDataOut, expOut);
    end
    i_pbm_far.push(W0);
    for (int i = 0; i < 4; i++) begin
      pb(1, 2'h2, 2'h0, 0, 0);
      idle;
      expOut[8:0] = W0[9*i +: 9];
      chk(portBDataOut, expOut);
    end
    pb(1, 2'h0, 2'h0, 1, 0);
    idle;
    chk(portBDataOut, expOut);
    pb(1, 2'h3, 2'h0, 1, 0);
    idle;
    chk(portBDataOut, MO);
    chk(portBDataOe, 1);
    axr(OFS_STATUS, 32'hf, RESP_OKAY);
    axw(OFS_STATUS, 32'hf, RESP_OKAY);
    axr(OFS_STATUS, 32'h0, RESP_OKAY);
    $display("read test done");
  endtask

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_writes;
    t_reads;
    end_of_test;
  end

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    end_of_test;
  end
endmodule
`default_nettype wire
